// >>> pkg/rvt_pkg.sv
`default_nettype none
package rvt_pkg;
	// Packet shape
	localparam int PKT_MAX_PAYLOAD = 20;	// Payload symbols per normal packet
	localparam int PKT_MAX_LEN     = 21;	// Head plus payload
	localparam int LOW_BW_PAYLOAD  = 1;	// Payload symbols per low bandwidth packet
	// Voucher limits at the source
	localparam int SRC_NORM_VOUCH  = 3;	// Per normal transmit FIFO
	localparam int SRC_LOW_VOUCH   = 1;	// Low bandwidth FIFO
	localparam int SRC_TOTAL_VOUCH = 7;	// Whole node
	// Target capacity
	localparam int TGT_NORM_TICKETS = 3;
	localparam int TGT_LOW_TICKETS  = 6;
	localparam int TGT_NORM_QUEUE   = 30;
	localparam int TGT_LOW_QUEUE    = 10;
	// Retry delay after a rejected voucher, in device clocks
	localparam int RETRY_CYCLES     = 100;
	// Device clocks an answer stands on the link; three slow link periods
	localparam int ANS_HOLD         = 48;
	// Early type lead in clocks
	localparam int LEAD_PIPE        = 3;
	localparam int LEAD_NOPIPE      = 2;
	localparam int EARLY_WINDOW     = 20;
	// Symbol types on the client ports
	localparam logic [1:0] TYPE_NULL = 2'h0;
	localparam logic [1:0] TYPE_HEAD = 2'h1;
	localparam logic [1:0] TYPE_PAY  = 2'h2;
	localparam logic [1:0] TYPE_TAIL = 2'h3;
	// Access symbol codes on the link
	localparam logic [1:0] ACC_NONE   = 2'h0;
	localparam logic [1:0] ACC_VOUCH  = 2'h1;
	localparam logic [1:0] ACC_TICKET = 2'h2;
	localparam logic [1:0] ACC_REJECT = 2'h3;

	// A symbol with its type
	typedef struct packed {
		logic [1:0]  kind;
		logic        low_bw_class;
		logic [31:0] data;
	} rvt_sym_s;

	// An access symbol on the link
	typedef struct packed {
		logic [1:0] code;
		logic       low_bw_class;
	} rvt_acc_s;
endpackage : rvt_pkg
`default_nettype wire

// >>> core/rvt_rx_delay.sv
`timescale 1ns/10ps
`default_nettype none
// Receive delay line that makes the data trail its early type by DEPTH clocks, or one fewer when sel_short is set
module rvt_rx_delay #(
	parameter int DEPTH = 3
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic             ce,
	// Stream
	input  wire logic             adv,
	input  wire logic             sel_short,
	input  wire rvt_pkg::rvt_sym_s in_sym,
	output var  rvt_pkg::rvt_sym_s out_sym
);
	rvt_pkg::rvt_sym_s stage [DEPTH];	// Shift stages
	rvt_pkg::rvt_sym_s next_stage [DEPTH];

	// Shift on advance only, so a hold freezes every stage
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			next_stage[i] = stage[i];
		end
		if (adv) begin
			next_stage[0] = in_sym;
			for (int i = 1; i < DEPTH; i++) begin
				next_stage[i] = stage[i-1];
			end
		end
	end

	// Register stages
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage[i] <= '0;
			end
		end else if (ce) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage[i] <= next_stage[i];
			end
		end
	end

	// Short timing taps one stage earlier
	assign out_sym = sel_short ? stage[DEPTH-2] : stage[DEPTH-1];
endmodule : rvt_rx_delay
`default_nettype wire

// >>> core/rvt_flow.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RULE1: Extra voucher once one packet cannot suffice
// RULE2: No packet sent before matching ticket
// RULE3: Send packets without waiting for more data
// RULE4: Normal packet is head plus twenty payloads
// RULE5: Low bandwidth packet is head plus one
// RULE6: Client writes at most twenty after space-ok drops
// RULE7: Client count restarts when space-ok rises
// RULE8: Voucher with room gets ticket immediately
// RULE9: Grants limited to three normal, six low
// RULE10: Queue thirty normal, ten low vouchers
// RULE11: Tail leaving receive FIFO frees one ticket
// RULE12: Reject voucher that can't be granted or queued
// RULE13: Rejected voucher resent after 100 clocks
// RULE14: Strip heads unless stream changes
// RULE15: Symbol every clock, stop during hold
// RULE16: Early type up to twenty symbols ahead
// RULE17: Pipelined timing leads by three clocks
// RULE18: Non-pipelined timing leads by two clocks
// RULE19: At most seven vouchers outstanding
// RULE20: Voucher on first and twenty-first symbol
// RULE21: Last payload marked as tail
// RULE22: Rejected voucher not counted as granted
module rvt_flow #(
	parameter int NQ_DEPTH = rvt_pkg::TGT_NORM_QUEUE,
	parameter int LQ_DEPTH = rvt_pkg::TGT_LOW_QUEUE
) (
	// Clock, reset, enable
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	input  wire logic              ce,
	// Link clock domain
	input  wire logic              link_clk,
	input  wire logic              link_rst_n,
	input  wire rvt_pkg::rvt_acc_s link_acc_in,
	output var  rvt_pkg::rvt_acc_s link_acc_out,
	// Client transmit
	input  wire rvt_pkg::rvt_sym_s tx_sym,
	output logic                   tx_space_ok,
	output var  rvt_pkg::rvt_sym_s tx_pkt_sym,
	// Incoming packet symbols for the target
	input  wire rvt_pkg::rvt_sym_s rx_in_sym,
	// Client receive
	input  wire logic              rx_hold,
	input  wire logic              rx_pipe_sel,
	output var  rvt_pkg::rvt_sym_s rx_symbol_bus,
	output logic [1:0]             rx_early_type
);
	// ---------------- Link crossing: access symbols, level sync both ways
	rvt_pkg::rvt_acc_s acc_in_s1, acc_in_s2;	// Two-flop sync into core
	rvt_pkg::rvt_acc_s acc_core_out, ans_q, next_ans;	// Core symbol and its held copy
	rvt_pkg::rvt_acc_s acc_out_s1;		// First flop on link side
	// Access symbols are held several clocks by the peer, so level sync holds
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_in_s1 <= '0;
			acc_in_s2 <= '0;
		end else if (ce) begin
			acc_in_s1 <= link_acc_in;
			acc_in_s2 <= acc_in_s1;
		end
	end
	// Outgoing side on link clock; the held copy outlasts two link edges
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			acc_out_s1   <= '0;
			link_acc_out <= '0;
		end else begin
			acc_out_s1   <= ans_q;
			link_acc_out <= acc_out_s1;
		end
	end
	// One-cycle pulse per new access symbol
	rvt_pkg::rvt_acc_s acc_prev;
	logic acc_new;
	assign acc_new = (acc_in_s2 != acc_prev) && (acc_in_s2.code != rvt_pkg::ACC_NONE);

	// ---------------- Source side
	logic [4:0] seg_cnt;	// Symbols under current head
	logic [2:0] vouch_out;	// Outstanding vouchers
	logic [2:0] tick_cnt;	// Received, unused tickets
	logic [4:0] pay_cnt;	// Payloads in current packet
	logic [6:0] retry_cnt;	// Retry delay
	logic       retry_wait;	// Rejected voucher pending
	logic [4:0] next_seg_cnt, next_pay_cnt;
	logic [2:0] next_vouch_out, next_tick_cnt;
	logic [6:0] next_retry_cnt, ans_cnt, next_ans_cnt;	// Answer hold count too
	logic       next_retry_wait, vouch_req, src_send, vouch_lb, retry_lb, next_retry_lb;
	rvt_pkg::rvt_sym_s next_tx_pkt;

	always_comb begin
		next_seg_cnt    = seg_cnt;
		next_vouch_out  = vouch_out;
		next_tick_cnt   = tick_cnt;
		next_pay_cnt    = pay_cnt;
		next_retry_cnt  = retry_cnt;
		next_retry_wait = retry_wait;
		next_retry_lb   = retry_lb;
		next_tx_pkt     = '0;
		vouch_req       = 1'b0;
		vouch_lb        = tx_sym.low_bw_class;
		src_send        = 1'b0;
		// Voucher at a head and again at the 21st symbol under that head
		if (tx_sym.kind != rvt_pkg::TYPE_NULL) begin
			next_seg_cnt = seg_cnt + 5'h01;
			if (tx_sym.kind == rvt_pkg::TYPE_HEAD || seg_cnt == 5'(rvt_pkg::PKT_MAX_PAYLOAD)) begin
				next_seg_cnt = 5'h01;	// RULE20 RULE1
				vouch_req    = 1'b1;
			end
		end
		// Retry count after a reject; the voucher is not granted meanwhile
		if (retry_wait) begin
			if (retry_cnt == 7'(rvt_pkg::RETRY_CYCLES - 1)) begin
				next_retry_wait = 1'b0;	// RULE13
				vouch_req       = 1'b1;
				vouch_lb        = retry_lb;
				next_retry_cnt  = 7'h00;
			end else begin
				next_retry_cnt = retry_cnt + 7'h01;
			end
		end
		if (vouch_req && vouch_out < 3'(rvt_pkg::SRC_TOTAL_VOUCH)) next_vouch_out = vouch_out + 3'h1;	// RULE19
		if (acc_new && acc_in_s2.code == rvt_pkg::ACC_TICKET) begin
			next_tick_cnt = tick_cnt + 3'h1;
			if (next_vouch_out != 3'h0) next_vouch_out = next_vouch_out - 3'h1;
		end
		if (acc_new && acc_in_s2.code == rvt_pkg::ACC_REJECT) begin
			next_retry_wait = 1'b1;	// RULE22
			next_retry_lb   = acc_in_s2.low_bw_class;
			next_retry_cnt  = 7'h00;
			if (next_vouch_out != 3'h0) next_vouch_out = next_vouch_out - 3'h1;
		end
		// Send whatever data there is once a ticket is held
		if (tx_sym.kind != rvt_pkg::TYPE_NULL && tick_cnt != 3'h0) begin	// RULE2 RULE3
			src_send    = 1'b1;
			next_tx_pkt = tx_sym;
			next_pay_cnt = pay_cnt + 5'h01;
			if (tx_sym.kind == rvt_pkg::TYPE_HEAD) begin
				next_pay_cnt = 5'h00;
			end else if (pay_cnt == 5'(rvt_pkg::PKT_MAX_PAYLOAD - 1) || tx_sym.low_bw_class
					|| tx_sym.kind == rvt_pkg::TYPE_TAIL) begin
				next_tx_pkt.kind = rvt_pkg::TYPE_TAIL;	// RULE21 RULE4 RULE5
				next_pay_cnt     = 5'h00;
				next_tick_cnt    = next_tick_cnt - 3'h1;
			end
		end
	end
	// Space-ok low while no ticket held; client obeys its twenty-symbol limit
	assign tx_space_ok = (tick_cnt != 3'h0);	// RULE6 RULE7

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			seg_cnt    <= '0;
			vouch_out  <= '0;
			tick_cnt   <= '0;
			pay_cnt    <= '0;
			retry_cnt  <= '0;
			retry_wait <= 1'b0;
			retry_lb   <= 1'b0;
			tx_pkt_sym <= '0;
			acc_prev   <= '0;
		end else if (ce) begin
			seg_cnt    <= next_seg_cnt;
			vouch_out  <= next_vouch_out;
			tick_cnt   <= next_tick_cnt;
			pay_cnt    <= next_pay_cnt;
			retry_cnt  <= next_retry_cnt;
			retry_wait <= next_retry_wait;
			retry_lb   <= next_retry_lb;
			tx_pkt_sym <= next_tx_pkt;
			acc_prev   <= acc_in_s2;
		end
	end

	// ---------------- Target side
	logic [2:0] norm_grant, next_norm_grant;	// Normal tickets out
	logic [2:0] low_grant,  next_low_grant;	// Low tickets out
	logic [4:0] norm_q, next_norm_q;		// Queued normal vouchers
	logic [3:0] low_q,  next_low_q;		// Queued low vouchers
	logic [1:0] last_stream, next_last_stream;	// Stream tag of last head
	logic       tail_out;			// Tail leaves receive FIFO
	logic       rx_adv;			// Pipeline advances
	rvt_pkg::rvt_sym_s strip_sym;			// After head stripper

	assign rx_adv   = !rx_hold;	// RULE15
	assign tail_out = rx_adv && rx_symbol_bus.kind == rvt_pkg::TYPE_TAIL;

	always_comb begin
		next_norm_grant  = norm_grant;
		next_low_grant   = low_grant;
		next_norm_q      = norm_q;
		next_low_q       = low_q;
		next_last_stream = last_stream;
		acc_core_out     = '0;
		strip_sym        = rx_in_sym;
		// Own voucher goes out unless a target answer takes the slot
		if (vouch_req && vouch_out < 3'(rvt_pkg::SRC_TOTAL_VOUCH)) acc_core_out = '{rvt_pkg::ACC_VOUCH, vouch_lb};
		// Free a ticket per tail leaving; serve a queued voucher with it
		if (tail_out) begin	// RULE11
			if (rx_symbol_bus.low_bw_class ? low_q != 4'h0 : norm_q != 5'h00) begin
				acc_core_out = '{rvt_pkg::ACC_TICKET, rx_symbol_bus.low_bw_class};
			end
			if (rx_symbol_bus.low_bw_class) begin
				if (low_q != 4'h0) next_low_q = low_q - 4'h1;
				else next_low_grant = low_grant - 3'h1;
			end else begin
				if (norm_q != 5'h00) next_norm_q = norm_q - 5'h01;
				else next_norm_grant = norm_grant - 3'h1;
			end
		end
		if (acc_new && acc_in_s2.code == rvt_pkg::ACC_VOUCH) begin
			acc_core_out.low_bw_class = acc_in_s2.low_bw_class;
			if (acc_in_s2.low_bw_class) begin
				if (low_grant < 3'(rvt_pkg::TGT_LOW_TICKETS)) begin	// RULE9
					next_low_grant    = next_low_grant + 3'h1;
					acc_core_out.code = rvt_pkg::ACC_TICKET;	// RULE8
				end else if (low_q < 4'(LQ_DEPTH)) begin
					next_low_q = next_low_q + 4'h1;	// RULE10
				end else begin
					acc_core_out.code = rvt_pkg::ACC_REJECT;	// RULE12
				end
			end else begin
				if (norm_grant < 3'(rvt_pkg::TGT_NORM_TICKETS)) begin	// RULE9
					next_norm_grant   = next_norm_grant + 3'h1;
					acc_core_out.code = rvt_pkg::ACC_TICKET;	// RULE8
				end else if (norm_q < 5'(NQ_DEPTH)) begin
					next_norm_q = next_norm_q + 5'h01;	// RULE10
				end else begin
					acc_core_out.code = rvt_pkg::ACC_REJECT;	// RULE12
				end
			end
		end
		// Drop heads that repeat the current stream
		if (rx_in_sym.kind == rvt_pkg::TYPE_HEAD) begin
			next_last_stream = rx_in_sym.data[31:30];
			if (rx_in_sym.data[31:30] == last_stream) strip_sym = '0;	// RULE14
		end
		// Hold each answer so the slow link sees it, then idle between answers
		next_ans_cnt = (ans_cnt != 7'h00) ? ans_cnt - 7'h01 : 7'h00;
		next_ans     = (ans_cnt == 7'h01) ? '0 : ans_q;
		if (acc_core_out.code != rvt_pkg::ACC_NONE) begin
			next_ans     = acc_core_out;
			next_ans_cnt = 7'(rvt_pkg::ANS_HOLD);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			norm_grant  <= '0;
			low_grant   <= '0;
			norm_q      <= '0;
			low_q       <= '0;
			last_stream <= '0;
			ans_q       <= '0;
			ans_cnt     <= '0;
		end else if (ce) begin
			norm_grant  <= next_norm_grant;
			low_grant   <= next_low_grant;
			norm_q      <= next_norm_q;
			low_q       <= next_low_q;
			last_stream <= next_last_stream;
			ans_q       <= next_ans;
			ans_cnt     <= next_ans_cnt;
		end
	end

	// Early type taps the stripper output; data trails by the chosen lead
	assign rx_early_type = strip_sym.kind;	// RULE16
	rvt_rx_delay #(
		.DEPTH (rvt_pkg::LEAD_PIPE)
	) u_delay (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.ce        (ce),
		.adv       (rx_adv),
		.sel_short (!rx_pipe_sel),	// RULE17 RULE18
		.in_sym    (strip_sym),
		.out_sym   (rx_symbol_bus)
	);

	// Checks
	sequence s_vouch_in;
		acc_new && acc_in_s2.code == rvt_pkg::ACC_VOUCH;
	endsequence
	a_no_send_ticket: assert property (@(posedge ref_clk) disable iff (!arst_n)	// RULE2
		ce && tx_pkt_sym.kind != rvt_pkg::TYPE_NULL |-> $past(tick_cnt) != 3'h0)
		else $error("packet sent without ticket");
	a_grant_limit: assert property (@(posedge ref_clk) disable iff (!arst_n)	// RULE9
		norm_grant <= 3'(rvt_pkg::TGT_NORM_TICKETS)) else $error("normal grant over limit");
	a_low_limit: assert property (@(posedge ref_clk) disable iff (!arst_n)	// RULE9
		low_grant <= 3'(rvt_pkg::TGT_LOW_TICKETS)) else $error("low grant over limit");
	a_queue_limit: assert property (@(posedge ref_clk) disable iff (!arst_n)	// RULE10
		norm_q <= 5'(NQ_DEPTH) && low_q <= 4'(LQ_DEPTH)) else $error("queue over");
	a_reject_full: assert property (@(posedge ref_clk) disable iff (!arst_n)	// RULE12
		s_vouch_in ##0 (acc_core_out.code == rvt_pkg::ACC_REJECT)
		|-> (norm_q == 5'(NQ_DEPTH) || low_q == 4'(LQ_DEPTH))) else $error("bad reject");
	a_retry_delay: assert property (@(posedge ref_clk) disable iff (!arst_n)	// RULE13
		$rose(retry_wait) && ce |-> ##[99:100] !retry_wait) else $error("retry delay");
	a_vouch_max: assert property (@(posedge ref_clk) disable iff (!arst_n)	// RULE19
		vouch_out <= 3'(rvt_pkg::SRC_TOTAL_VOUCH)) else $error("too many vouchers");
	a_pipe_lead: assert property (@(posedge ref_clk) disable iff (!arst_n)	// RULE17
		ce && rx_adv && rx_pipe_sel ##1 ce && rx_adv ##1 ce && rx_adv
		|=> rx_symbol_bus.kind == $past(rx_early_type, 3)) else $error("lead wrong");
endmodule : rvt_flow
`default_nettype wire

// >>> sim/rvt_peer.sv
`timescale 1ns/10ps
`default_nettype none
// Peer ring node: sends access symbols, tallies the node's answers
module rvt_peer (
	// Link clock and reset
	input  wire logic              link_clk,
	input  wire logic              link_rst_n,
	// Access symbols both ways
	input  wire rvt_pkg::rvt_acc_s acc_from_dut,
	output var  rvt_pkg::rvt_acc_s acc_to_dut
);
	int                n_vouch = 0;	// Vouchers seen
	int                n_tick  = 0;	// Tickets seen
	int                n_rej   = 0;	// Rejects seen
	rvt_pkg::rvt_acc_s last    = '0;	// Previous symbol, so a held one counts once
	initial acc_to_dut = '0;
	// Tally each new non-null symbol
	always @(posedge link_clk) begin
		if (link_rst_n && acc_from_dut !== last && acc_from_dut.code !== 2'h0) begin
			case (acc_from_dut.code)
				rvt_pkg::ACC_VOUCH: n_vouch++;
				rvt_pkg::ACC_TICKET: n_tick++;
				default: n_rej++;
			endcase
		end
		last <= acc_from_dut;
	end
	// One symbol for one link cycle, then back to none between symbols
	task automatic send(input logic [1:0] code, input logic lb);
		@(posedge link_clk);
		acc_to_dut <= '{code, lb};
		@(posedge link_clk);
		acc_to_dut <= '0;
		@(posedge link_clk);
	endtask : send
endmodule : rvt_peer
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the voucher and ticket flow block
module tb;
	logic              ref_clk     = 1'b0;
	logic              link_clk    = 1'b0;
	logic              arst_n      = 1'b0;
	logic              link_rst_n  = 1'b0;
	logic              ce          = 1'b1;	// Always running
	rvt_pkg::rvt_acc_s acc_in;
	rvt_pkg::rvt_acc_s acc_out;
	rvt_pkg::rvt_sym_s tx_sym      = '0;
	logic              tx_space_ok;
	rvt_pkg::rvt_sym_s tx_pkt_sym;
	rvt_pkg::rvt_sym_s rx_in_sym   = '0;
	logic              rx_hold     = 1'b0;
	logic              rx_pipe_sel = 1'b1;
	rvt_pkg::rvt_sym_s rx_symbol_bus;
	logic [1:0]        rx_early_type;
	int                failures    = 0;
	int                checks_done = 0;
	int                rx_heads    = 0;	// Heads seen at the receive port
	logic [1:0]        pkt_q[$];	// Kinds sent on the transmit side
	always #5 ref_clk = ~ref_clk;
	// Link clock, edges always on core clock falling edges, never on rising ones
	always #80 link_clk = ~link_clk;
	// Short queues keep the fill quick
	rvt_flow #(.NQ_DEPTH(2), .LQ_DEPTH(2)) DUT (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce),
		.link_clk(link_clk), .link_rst_n(link_rst_n), .link_acc_in(acc_in),
		.link_acc_out(acc_out), .tx_sym(tx_sym), .tx_space_ok(tx_space_ok),
		.tx_pkt_sym(tx_pkt_sym), .rx_in_sym(rx_in_sym), .rx_hold(rx_hold),
		.rx_pipe_sel(rx_pipe_sel), .rx_symbol_bus(rx_symbol_bus),
		.rx_early_type(rx_early_type));
	rvt_peer peer (.link_clk(link_clk), .link_rst_n(link_rst_n), .acc_from_dut(acc_out),
		.acc_to_dut(acc_in));
	// Record transmitted kinds and receive-side heads
	always @(posedge ref_clk) begin
		if (arst_n && tx_pkt_sym.kind !== rvt_pkg::TYPE_NULL) begin
			pkt_q.push_back(tx_pkt_sym.kind);
		end
		if (rx_symbol_bus.kind === rvt_pkg::TYPE_HEAD) begin
			rx_heads++;
		end
	end
	task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	// Client writes head, payloads and a closing tail, one per clock
	task automatic drive_pkt(input logic lb, input int npay);
		logic [1:0] kd;
		for (int k = 0; k <= npay; k++) begin
			kd = (k == 0) ? rvt_pkg::TYPE_HEAD : (k == npay ? rvt_pkg::TYPE_TAIL : rvt_pkg::TYPE_PAY);
			@(posedge ref_clk);
			tx_sym <= '{kd, lb, 32'h00000100 + k};
		end
		@(posedge ref_clk);
		tx_sym <= '0;
	endtask : drive_pkt
	// Client stream leaves only after a ticket, last payload as tail
	task automatic src_pkt(input logic lb, input int npay, input logic rej);
		int v0;
		int k;
		v0 = peer.n_vouch;
		pkt_q.delete();
		drive_pkt(lb, npay);
		for (k = 0; k < 400 && peer.n_vouch == v0; k++) @(posedge ref_clk);
		repeat (20) @(posedge ref_clk);
		check("vouchers", peer.n_vouch - v0, 1);
		check("early pkt", pkt_q.size(), 0);
		if (rej) begin
			peer.send(rvt_pkg::ACC_REJECT, lb);
			#500;
			check("early retry", peer.n_vouch - v0, 1);
			for (k = 0; k < 300 && peer.n_vouch == v0 + 1; k++) @(posedge ref_clk);
			check("retry", peer.n_vouch - v0, 2);
			check("pkt held", pkt_q.size(), 0);
		end
		peer.send(rvt_pkg::ACC_TICKET, lb);
		// Data written before the ticket is not kept; write again once space opens
		for (k = 0; k < 300 && !tx_space_ok; k++) @(posedge ref_clk);
		drive_pkt(lb, npay);
		for (k = 0; k < 300 && pkt_q.size() < npay + 1; k++) @(posedge ref_clk);
		repeat (30) @(posedge ref_clk);
		check("pkt len", pkt_q.size(), npay + 1);
		for (k = 0; k < pkt_q.size(); k++) begin
			check("kind", pkt_q[k], k == 0 ? 1 : (k == npay ? 3 : 2));
		end
		// Let the rewrite's own voucher clear the link before the next count
		repeat (8) @(posedge link_clk);
	endtask : src_pkt
	// Tickets up to the limit, then queued, then one reject
	task automatic tgt_fill(input logic lb, input int ntick);
		int t0;
		int r0;
		int k;
		t0 = peer.n_tick;
		r0 = peer.n_rej;
		for (k = 0; k < ntick + 3; k++) begin
			peer.send(rvt_pkg::ACC_VOUCH, lb);
			repeat (4) @(posedge link_clk);
			check("tickets", peer.n_tick - t0, k < ntick ? k + 1 : ntick);
		end
		check("rejects", peer.n_rej - r0, 1);
	endtask : tgt_fill
	// Packet into the target; data trails its early type by the lead
	task automatic rx_pkt(input logic sel, input logic [1:0] tag, input logic [31:0] d);
		rx_pipe_sel <= sel;
		@(posedge ref_clk);
		rx_in_sym <= '{rvt_pkg::TYPE_HEAD, 1'b0, {tag, 30'h00000000}};
		@(posedge ref_clk);
		rx_in_sym <= '{rvt_pkg::TYPE_PAY, 1'b0, d};
		@(negedge ref_clk);
		check("early type", rx_early_type, rvt_pkg::TYPE_PAY);
		@(posedge ref_clk);
		rx_in_sym <= '{rvt_pkg::TYPE_TAIL, 1'b0, ~d};
		@(posedge ref_clk);
		rx_in_sym <= '0;
		// Payload was typed two edges back; the lead counts from that cycle
		repeat ((sel ? rvt_pkg::LEAD_PIPE : rvt_pkg::LEAD_NOPIPE) - 1) @(negedge ref_clk);
		check("rx lead", rx_symbol_bus, {rvt_pkg::TYPE_PAY, 1'b0, d});
	endtask : rx_pkt
	// Receive path, head stripping, ticket release and hold
	task automatic rx_all();
		int t0;
		int h0;
		rvt_pkg::rvt_sym_s seen;
		t0 = peer.n_tick;
		// Packets spaced so each freed ticket stands alone on the link
		rx_pkt(1'b1, 2'h1, 32'h11111111);
		repeat (120) @(posedge ref_clk);
		h0 = rx_heads;
		rx_pkt(1'b0, 2'h1, 32'h22222222);
		repeat (120) @(posedge ref_clk);
		check("same stream head", rx_heads - h0, 0);
		rx_pkt(1'b1, 2'h2, 32'h33333333);
		repeat (120) @(posedge ref_clk);
		check("new stream head", rx_heads - h0, 1);
		repeat (8) @(posedge link_clk);
		check("freed tickets", peer.n_tick - t0, 2);
		// Hold while the packet is inside the pipeline
		rx_pipe_sel <= 1'b1;
		@(posedge ref_clk);
		rx_in_sym <= '{rvt_pkg::TYPE_HEAD, 1'b0, {2'h2, 30'h00000000}};
		@(posedge ref_clk);
		rx_in_sym <= '{rvt_pkg::TYPE_PAY, 1'b0, 32'h44444444};
		@(posedge ref_clk);
		rx_in_sym <= '{rvt_pkg::TYPE_TAIL, 1'b0, 32'hBBBBBBBB};
		@(posedge ref_clk);
		rx_in_sym <= '0;
		rx_hold   <= 1'b1;
		@(negedge ref_clk);
		seen = rx_symbol_bus;
		repeat (8) @(negedge ref_clk);
		check("held", rx_symbol_bus, seen);
		@(posedge ref_clk);
		rx_hold <= 1'b0;
		for (int k = 0; k < 40 && rx_symbol_bus.data !== 32'h44444444; k++) @(negedge ref_clk);
		check("resumed", rx_symbol_bus, {rvt_pkg::TYPE_PAY, 1'b0, 32'h44444444});
	endtask : rx_all
	initial begin
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge link_clk);
		link_rst_n <= 1'b1;
		repeat (2) @(posedge link_clk);
		src_pkt(1'b0, 3, 1'b1);
		src_pkt(1'b1, 1, 1'b0);
		tgt_fill(1'b0, 3);
		tgt_fill(1'b1, 6);
		rx_all();
		wrap_up();
	end
	// Hang guard
	initial begin
		#400000;
		failures++;
		wrap_up();
	end
endmodule : tb
`default_nettype wire
